// File: src/itp_pkg.sv
// Constants shared by the interval timer design.
// Assumes a single 125 MHz system clock drives all logic.
package itp_pkg;
	// Counter set
	localparam int NUM_CNT = 3;
	localparam int CNT_W = 16;
	// Port index decode
	localparam logic [1:0] PORT_CTRL = 2'h3;
	// Control word field positions
	localparam int CW_SC_HI = 7;
	localparam int CW_SC_LO = 6;
	localparam int CW_RW_HI = 5;
	localparam int CW_RW_LO = 4;
	localparam int CW_MODE_HI = 3;
	localparam int CW_MODE_LO = 1;
	localparam int CW_BCD = 0;
	localparam logic [1:0] SC_READBACK = 2'h3;
	// Read-back field positions
	localparam int RB_LATCH_VAL = 5;
	localparam int RB_LATCH_ST = 4;
	localparam int RB_MASK_LO = 1;
	// Byte order codes
	localparam logic [1:0] RW_LATCH = 2'h0;
	localparam logic [1:0] RW_LO = 2'h1;
	localparam logic [1:0] RW_HI = 2'h2;
	localparam logic [1:0] RW_BOTH = 2'h3;
	// Mode codes
	localparam logic [2:0] MODE_0 = 3'h0;
	localparam logic [2:0] MODE_1 = 3'h1;
	// Status byte layout
	localparam int ST_OUT = 7;
	localparam int ST_NULL = 6;
	// Reset values
	localparam logic [5:0] CW_RST = 6'h00;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
endpackage

// File: src/itp_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is an independent level from outside clk_in.
module itp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Pin side and clock side
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// First stage feeds only the second
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule

// File: src/itp_counter_core.sv
// One timer channel: preload, down counter, trigger edge store, output.
// Assumes clock and enable edges arrive as synchronised one-cycle pulses.
module itp_counter_core (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Programming strobes
	input wire logic cw_stb_in,
	input wire logic first_byte_in,
	input wire logic count_stb_in,
	input wire logic [itp_pkg::CNT_W-1:0] count_val_in,
	input wire logic [2:0] mode_in,
	input wire logic bcd_in,
	// Timer pin events
	input wire logic tclk_rise_in,
	input wire logic tclk_fall_in,
	input wire logic gate_in,
	input wire logic gate_rise_in,
	// State
	output logic [itp_pkg::CNT_W-1:0] count_out,
	output logic out_level_out,
	output logic null_count_out
);
	import itp_pkg::*;

	logic [CNT_W-1:0] cr_q;
	logic [CNT_W-1:0] ce_q;
	logic out_q, null_q, load_pend_q, armed_q, halt_q;
	logic gate_smp_q, trig_ff_q, trig_smp_q;
	logic load_now;

	// Down count with wrap: binary to ffff, decimal to 9999
	function automatic logic [CNT_W-1:0] dec_cnt(
		input logic [CNT_W-1:0] v, input logic bcd);
		logic [CNT_W-1:0] r;
		logic brw;
		r = v;
		brw = 1'b1;
		if (!bcd) begin
			r = CNT_W'(v - 16'h0001);
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (brw) begin
					if (v[4*i +: 4] == 4'h0) begin
						r[4*i +: 4] = 4'h9;
					end else begin
						r[4*i +: 4] = 4'(v[4*i +: 4] - 4'h1);
						brw = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction

	// Edge store so a short trigger between clock pulses is kept
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			trig_ff_q <= 1'b0;
			trig_smp_q <= 1'b0;
			gate_smp_q <= 1'b0;
		end else begin
			if (gate_rise_in) begin
				trig_ff_q <= 1'b1;
			end else if (tclk_rise_in) begin
				trig_ff_q <= 1'b0;
			end
			if (tclk_rise_in) begin
				trig_smp_q <= trig_ff_q | gate_rise_in;
				gate_smp_q <= gate_in;
			end
		end
	end

	// Copy of preload into counter on this clock pulse
	assign load_now = tclk_fall_in && !cw_stb_in && !count_stb_in &&
		((mode_in == MODE_1) ? (armed_q && trig_smp_q) : load_pend_q);

	// Counting and output level
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cr_q <= CNT_RST;
			ce_q <= CNT_RST;
			out_q <= 1'b1;
			load_pend_q <= 1'b0;
			armed_q <= 1'b0;
			halt_q <= 1'b1;
		end else if (cw_stb_in) begin
			cr_q <= CNT_RST;
			load_pend_q <= 1'b0;
			armed_q <= 1'b0;
			halt_q <= 1'b1;
			out_q <= (mode_in != MODE_0);
		end else if (count_stb_in) begin
			cr_q <= count_val_in;
			if (mode_in == MODE_1) begin
				armed_q <= 1'b1;
			end else begin
				load_pend_q <= 1'b1;
				halt_q <= 1'b0;
				if (mode_in == MODE_0) begin
					out_q <= 1'b0;
				end
			end
		end else if (first_byte_in && mode_in == MODE_0) begin
			halt_q <= 1'b1;
			out_q <= 1'b0;
		end else if (tclk_fall_in) begin
			if (load_now) begin
				ce_q <= cr_q;
				load_pend_q <= 1'b0;
				if (mode_in == MODE_1) begin
					out_q <= 1'b0;
				end
			end else if (mode_in == MODE_1) begin
				ce_q <= dec_cnt(ce_q, bcd_in);
				if (ce_q == 16'h0001) begin
					out_q <= 1'b1;
				end
			end else if (!halt_q && gate_smp_q) begin
				ce_q <= dec_cnt(ce_q, bcd_in);
				if (mode_in == MODE_0 && ce_q == 16'h0001) begin
					out_q <= 1'b1;
				end
			end
		end
	end

	// Reload pending flag, a write wins over a load
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			null_q <= 1'b0;
		end else if (cw_stb_in || count_stb_in) begin
			null_q <= 1'b1;
		end else if (load_now) begin
			null_q <= 1'b0;
		end
	end

	assign count_out = ce_q;
	assign out_level_out = out_q;
	assign null_count_out = null_q;
endmodule

// File: src/itp_timer_top.sv
// Three channel interval timer with 8-bit host port and readback.
// Assumes the host drives the strobes per the timer bus protocol
// and that a control word arrives whole, in one strobe;
// all pins are sampled by the 125 MHz system clock.
module itp_timer_top (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Host port
	input wire logic select_n_in,
	input wire logic read_strobe_n_in,
	input wire logic store_strobe_n_in,
	input wire logic [1:0] port_index_in,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_out,
	// Timer pins
	input wire logic [itp_pkg::NUM_CNT-1:0] tmr_clk_in,
	input wire logic [itp_pkg::NUM_CNT-1:0] enable_trigger_in,
	output logic [itp_pkg::NUM_CNT-1:0] timer_pin_out
);
	import itp_pkg::*;

	// Sync order: strobes, index, data, timer clocks, enables
	localparam int SW = 5 + 8 + 2 * NUM_CNT;

	logic [SW-1:0] sync_w;
	logic sel_n_s, rd_n_s, wr_n_s;
	logic [1:0] idx_s;
	logic [7:0] dat_s;
	logic [NUM_CNT-1:0] tclk_s, gate_s;
	logic wr_act_q, rd_act_q;
	logic [NUM_CNT-1:0] tclk_q, gate_q;
	logic wr_act, rd_act, wr_take, rd_end;
	logic [1:0] idx_hold_q;
	logic [7:0] dat_out_q;
	logic oe_q;
	logic [NUM_CNT-1:0] pin_q;
	logic [7:0] rd_byte_w [NUM_CNT];
	logic [NUM_CNT-1:0] out_lvl_w;

	// True when a command targets counter n
	function automatic logic hits(input logic [1:0] sel, input int n);
		return sel == 2'(n);
	endfunction

	// Modes whose low enable level overrides the output pin
	function automatic logic gate_forced(input logic [2:0] m);
		return m == 3'h2 || m == 3'h3;
	endfunction

	// Every pin crosses into the clock domain before use. The active-low
	// strobes are inverted ahead of the first flop so that the cleared
	// flops read as an idle bus; otherwise the first cycles after reset
	// would look like a read and a write at port 0.
	itp_sync #(
		.W(SW)
	) u_sync (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in({~select_n_in, ~read_strobe_n_in, ~store_strobe_n_in,
			port_index_in, data_in, tmr_clk_in, enable_trigger_in}),
		.sync_out(sync_w)
	);

	assign sel_n_s = !sync_w[SW-1];
	assign rd_n_s = !sync_w[SW-2];
	assign wr_n_s = !sync_w[SW-3];
	assign idx_s = sync_w[SW-4 -: 2];
	assign dat_s = sync_w[SW-6 -: 8];
	assign tclk_s = sync_w[2*NUM_CNT-1 -: NUM_CNT];
	assign gate_s = sync_w[NUM_CNT-1:0];

	// Bus strobes only count while selected
	assign wr_act = !sel_n_s && !wr_n_s;
	assign rd_act = !sel_n_s && !rd_n_s;

	// Edge history for strobes and timer pins
	// Cleared history matches the idle levels, so no false edge at reset
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
			idx_hold_q <= 2'h0;
			tclk_q <= '0;
			gate_q <= '0;
		end else begin
			wr_act_q <= wr_act;
			rd_act_q <= rd_act;
			tclk_q <= tclk_s;
			gate_q <= gate_s;
			if (rd_act) begin
				idx_hold_q <= idx_s;
			end
		end
	end

	// Write taken at strobe start, read retired at strobe end
	// Retiring late keeps the byte pointer still while the data stands
	assign wr_take = wr_act && !wr_act_q;
	assign rd_end = rd_act_q && !rd_act;

	// Per counter programming, latching and read sequencing
	for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
		logic [5:0] cw_q;
		logic wr_hi_q, rd_hi_q, ol_full_q, st_full_q;
		logic [7:0] lo_q, st_q;
		logic [15:0] ol_q;
		logic [15:0] cnt_w;
		logic null_w;
		logic port_wr, ctrl_wr, prog_wr, latch_wr, rb_wr, rd_done;
		logic cnt_stb, first_stb;
		logic [15:0] val_w, src_w;
		logic [1:0] rw_w;
		logic [2:0] mode_w;
		logic [5:0] cw_w;

		assign rw_w = cw_q[CW_RW_HI:CW_RW_LO];
		// A new control word sets the start level in the cycle it lands,
		// so the core must see the incoming mode, not the stored one
		assign cw_w = prog_wr ? dat_s[5:0] : cw_q;
		// Modes 6 and 7 behave as modes 2 and 3
		assign mode_w = (cw_w[CW_MODE_HI:CW_MODE_HI-1] == 2'h3) ?
			{1'b0, cw_w[CW_MODE_HI-1:CW_MODE_LO]} :
			cw_w[CW_MODE_HI:CW_MODE_LO];

		// Address decode for this channel
		// Latch and read-back words never reprogram a counter
		assign port_wr = wr_take && hits(idx_s, i);
		assign ctrl_wr = wr_take && idx_s == PORT_CTRL;
		assign prog_wr = ctrl_wr && hits(dat_s[CW_SC_HI:CW_SC_LO], i) &&
			dat_s[CW_RW_HI:CW_RW_LO] != RW_LATCH;
		assign latch_wr = ctrl_wr && hits(dat_s[CW_SC_HI:CW_SC_LO], i) &&
			dat_s[CW_RW_HI:CW_RW_LO] == RW_LATCH;
		assign rb_wr = ctrl_wr && dat_s[CW_SC_HI:CW_SC_LO] == SC_READBACK &&
			dat_s[RB_MASK_LO + i];
		assign rd_done = rd_end && hits(idx_hold_q, i);

		// Count byte assembly per programmed format
		// Format 00 writes fall to the default and are ignored
		always_comb begin
			cnt_stb = 1'b0;
			first_stb = 1'b0;
			val_w = {BYTE_RST, dat_s};
			case (rw_w)
				RW_LO: cnt_stb = port_wr;
				RW_HI: begin
					cnt_stb = port_wr;
					val_w = {dat_s, BYTE_RST};
				end
				RW_BOTH: begin
					cnt_stb = port_wr && wr_hi_q;
					first_stb = port_wr && !wr_hi_q;
					val_w = {dat_s, lo_q};
				end
				default: cnt_stb = 1'b0;
			endcase
		end

		// Control word store and write byte pointer
		// A control word restarts the byte pairing at the low byte
		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				cw_q <= CW_RST;
				wr_hi_q <= 1'b0;
				lo_q <= BYTE_RST;
			end else if (prog_wr) begin
				cw_q <= dat_s[5:0];
				wr_hi_q <= 1'b0;
				lo_q <= BYTE_RST;
			end else if (port_wr && rw_w == RW_BOTH) begin
				wr_hi_q <= !wr_hi_q;
				if (!wr_hi_q) begin
					lo_q <= dat_s;
				end
			end
		end

		// Snapshot and status latches with read pointer
		// A control word drops any latch still waiting to be read
		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				ol_q <= CNT_RST;
				ol_full_q <= 1'b0;
				st_q <= BYTE_RST;
				st_full_q <= 1'b0;
				rd_hi_q <= 1'b0;
			end else if (prog_wr) begin
				ol_full_q <= 1'b0;
				st_full_q <= 1'b0;
				rd_hi_q <= 1'b0;
			end else begin
				// First capture holds until read out
				if ((latch_wr || (rb_wr && dat_s[RB_LATCH_VAL])) &&
					!ol_full_q) begin
					ol_q <= cnt_w;
					ol_full_q <= 1'b1;
				end
				if (rb_wr && dat_s[RB_LATCH_ST] && !st_full_q) begin
					// Pin as driven, so a forced-high level shows too
					st_q <= {pin_q[i], null_w, cw_q};
					st_full_q <= 1'b1;
				end
				if (rd_done) begin
					if (st_full_q) begin
						st_full_q <= 1'b0;
					end else if (rw_w == RW_BOTH && !rd_hi_q) begin
						rd_hi_q <= 1'b1;
					end else begin
						rd_hi_q <= 1'b0;
						ol_full_q <= 1'b0;
					end
				end
			end
		end

		// Status first, then snapshot, else live count
		// The live count may move between the two bytes of a plain read
		assign src_w = ol_full_q ? ol_q : cnt_w;
		assign rd_byte_w[i] = st_full_q ? st_q :
			((rw_w == RW_HI || (rw_w == RW_BOTH && rd_hi_q)) ?
			src_w[15:8] : src_w[7:0]);

		// Timer clock and enable edges come from the synced pins
		itp_counter_core u_core (
			.clk_in(clk_in),
			.sys_rst_in(sys_rst_in),
			.cw_stb_in(prog_wr),
			.first_byte_in(first_stb),
			.count_stb_in(cnt_stb),
			.count_val_in(val_w),
			.mode_in(mode_w),
			.bcd_in(cw_q[CW_BCD]),
			.tclk_rise_in(tclk_s[i] && !tclk_q[i]),
			.tclk_fall_in(!tclk_s[i] && tclk_q[i]),
			.gate_in(gate_s[i]),
			.gate_rise_in(gate_s[i] && !gate_q[i]),
			.count_out(cnt_w),
			.out_level_out(out_lvl_w[i]),
			.null_count_out(null_w)
		);

		// Modes 2 and 3 force the pin high while enable is low; the
		// override sits after the core so its own state is untouched
		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				pin_q[i] <= 1'b1;
			end else if (gate_forced(mode_w) && !gate_s[i]) begin
				pin_q[i] <= 1'b1;
			end else begin
				pin_q[i] <= out_lvl_w[i];
			end
		end
	end

	// Read data driven only for counter ports; control reads float
	// The byte is refreshed every cycle, so a live read shows the
	// count of the moment; the host takes it once oe is seen
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			dat_out_q <= BYTE_RST;
			oe_q <= 1'b0;
		end else begin
			oe_q <= rd_act && idx_s != PORT_CTRL;
			case (idx_s)
				2'h0: dat_out_q <= rd_byte_w[0];
				2'h1: dat_out_q <= rd_byte_w[1];
				2'h2: dat_out_q <= rd_byte_w[2];
				default: dat_out_q <= BYTE_RST;
			endcase
		end
	end

	assign data_out = dat_out_q;
	assign data_oe_out = oe_q;
	assign timer_pin_out = pin_q;
endmodule

// File: tb/itp_timer_monitor.sv
// Checker for the timer top: host port float rules and pin events.
// Assumes it is bound to itp_timer_top and sees only its ports.
module itp_timer_monitor
	import itp_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Host port
	input wire logic select_n_in,
	input wire logic read_strobe_n_in,
	input wire logic store_strobe_n_in,
	input wire logic [1:0] port_index_in,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe_out,
	// Timer pins
	input wire logic [itp_pkg::NUM_CNT-1:0] tmr_clk_in,
	input wire logic [itp_pkg::NUM_CNT-1:0] enable_trigger_in,
	input wire logic [itp_pkg::NUM_CNT-1:0] timer_pin_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// Host access shapes
	sequence s_rd_ctl;
		!select_n_in && !read_strobe_n_in && port_index_in == PORT_CTRL;
	endsequence
	sequence s_rd_cnt;
		!select_n_in && !read_strobe_n_in && port_index_in != PORT_CTRL;
	endsequence
	sequence s_idle;
		select_n_in || (read_strobe_n_in && store_strobe_n_in);
	endsequence
	sequence s_cw(n, m);
		!select_n_in && !store_strobe_n_in && port_index_in == PORT_CTRL &&
		data_in[7:6] == n && data_in[5:4] != RW_LATCH && data_in[3:1] == m;
	endsequence
	// Control port never answers a read
	property p_ctl_float;
		s_rd_ctl [*4] |-> !data_oe_out;
	endproperty
	property p_idle_float;
		s_idle [*6] |-> !data_oe_out;
	endproperty
	property p_oe_cause;
		$rose(data_oe_out) |-> s_rd_cnt;
	endproperty
	property p_rd_answer;
		s_rd_cnt [*4] |-> data_oe_out;
	endproperty
	// Mode set takes the pin to its start level with no timer clock
	property p_m0_low(n);
		s_cw(n, MODE_0) |-> ##[1:6] !timer_pin_out[n];
	endproperty
	property p_m1_high(n);
		s_cw(n, MODE_1) |-> ##[1:6] timer_pin_out[n];
	endproperty
	// Window of 8 covers the sync lag after the last clock fall
	property p_pin_hold;
		(!tmr_clk_in[0] && store_strobe_n_in &&
		$stable(enable_trigger_in[0])) [*8] |=> $stable(timer_pin_out[0]);
	endproperty
	a_ctl_float: assert property (p_ctl_float)
		else $error("read of control port drove the bus");
	a_idle_float: assert property (p_idle_float)
		else $error("bus driven while idle");
	a_oe_cause: assert property (p_oe_cause)
		else $error("bus driven without counter read");
	a_rd_answer: assert property (p_rd_answer)
		else $error("counter read not answered");
	a_m0_low0: assert property (p_m0_low(0))
		else $error("mode 0 set left pin 0 high");
	a_m0_low1: assert property (p_m0_low(1))
		else $error("mode 0 set left pin 1 high");
	a_m1_high2: assert property (p_m1_high(2))
		else $error("mode 1 set left pin 2 low");
	a_pin_hold: assert property (p_pin_hold)
		else $error("pin 0 moved without clock pulse");
endmodule
bind itp_timer_top itp_timer_monitor mon (.clk_in, .sys_rst_in,
	.select_n_in, .read_strobe_n_in, .store_strobe_n_in, .port_index_in,
	.data_in, .data_out, .data_oe_out, .tmr_clk_in, .enable_trigger_in,
	.timer_pin_out);

// File: tb/itp_host_model.sv
// Host bus master model for the timer's 8-bit port.
// Assumes tasks are called one at a time, just after a clk_in edge.
module itp_host_model (
	// Clock
	input wire logic clk_in,
	// Host port
	output logic select_n_out,
	output logic read_strobe_n_out,
	output logic store_strobe_n_out,
	output logic [1:0] port_index_out,
	output logic [7:0] data_out,
	input wire logic [7:0] data_in,
	input wire logic data_oe_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle bus
	initial begin
		select_n_out = 1'b1;
		read_strobe_n_out = 1'b1;
		store_strobe_n_out = 1'b1;
		port_index_out = 2'h0;
		data_out = 8'hff;
	end
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask
	// Whole access then a gap, so nothing slips between byte pairs
	task automatic wr(input logic [1:0] i, input logic [7:0] d);
		select_n_out = 1'b0;
		port_index_out = i;
		data_out = d;
		store_strobe_n_out = 1'b0;
		cyc(4);
		store_strobe_n_out = 1'b1;
		select_n_out = 1'b1;
		data_out = ~d; // Released bus shows no stale value
		cyc(4);
	endtask
	task automatic rd(input logic [1:0] i, output logic [7:0] d,
		output bit ok);
		ok = 1'b0;
		d = 8'h00;
		select_n_out = 1'b0;
		port_index_out = i;
		read_strobe_n_out = 1'b0;
		for (int n = 0; n < 8 && !ok; n++) begin
			cyc(1);
			ok = data_oe_in;
		end
		if (ok) begin
			d = data_in; // Settled byte, launched on the edge just seen
			cyc(1);
		end
		read_strobe_n_out = 1'b1;
		select_n_out = 1'b1;
		cyc(5);
	endtask
endmodule

// File: tb/interval_timer_program_readback_tb_top.sv
// Self-checking bench for the three channel interval timer.
// Assumes the host model drives the port and this module the pins.
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
	mismatches++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
	end end
module interval_timer_program_readback_tb_top
	import itp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_in, sys_rst_in, select_n, rd_n, wr_n, oe;
	logic [1:0] idx;
	logic [7:0] din, dout;
	logic [2:0] tclk, gate, pin;
	int mismatches = 0;
	int cmp_count = 0;
	itp_timer_top dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.select_n_in(select_n), .read_strobe_n_in(rd_n),
		.store_strobe_n_in(wr_n), .port_index_in(idx), .data_in(din),
		.data_out(dout), .data_oe_out(oe), .tmr_clk_in(tclk),
		.enable_trigger_in(gate), .timer_pin_out(pin));
	itp_host_model host (.clk_in(clk_in), .select_n_out(select_n),
		.read_strobe_n_out(rd_n), .store_strobe_n_out(wr_n),
		.port_index_out(idx), .data_out(din), .data_in(dout),
		.data_oe_in(oe));
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask
	// Slow timer clock: each level held well past the sync lag
	task automatic pulse(input int n, input int k);
		repeat (k) begin
			tclk[n] = 1'b1;
			cyc(4);
			tclk[n] = 1'b0;
			cyc(6);
		end
	endtask
	task automatic trig(input int n);
		gate[n] = 1'b0;
		cyc(4);
		gate[n] = 1'b1;
		cyc(4);
	endtask
	task automatic chkpin(input int n, input logic e);
		`CHK("pin", e, pin[n])
	endtask
	task automatic rdchk(input logic [1:0] i, input logic [7:0] e);
		logic [7:0] d;
		bit ok;
		host.rd(i, d, ok);
		if (!ok) begin
			$display("MISMATCH ack exp 1 got 0");
			mismatches++;
			end_of_test();
		end
		`CHK("rd", e, d)
	endtask
	task automatic t_port();
		logic [7:0] d;
		bit ok;
		`CHK("oe", 1'b0, oe)
		host.rd(PORT_CTRL, d, ok);
		`CHK("ack", 1'b0, ok)
		$display("t_port done");
	endtask
	task automatic t_mode0();
		gate[0] = 1'b1;
		host.wr(PORT_CTRL, 8'h10);
		chkpin(0, 1'b0);
		host.wr(2'h0, 8'h03);
		host.wr(PORT_CTRL, 8'hd2);
		rdchk(2'h0, 8'h50);
		pulse(0, 3);
		chkpin(0, 1'b0);
		pulse(0, 1);
		chkpin(0, 1'b1);
		host.wr(PORT_CTRL, 8'hd2);
		rdchk(2'h0, 8'h90);
		gate[0] = 1'b0;
		host.wr(2'h0, 8'h02);
		pulse(0, 3);
		chkpin(0, 1'b0);
		gate[0] = 1'b1;
		cyc(4);
		pulse(0, 1);
		chkpin(0, 1'b0);
		pulse(0, 1);
		chkpin(0, 1'b1);
		$display("t_mode0 done");
	endtask
	task automatic t_latch();
		gate[1] = 1'b1;
		host.wr(PORT_CTRL, 8'h70);
		host.wr(2'h1, 8'h02);
		host.wr(2'h1, 8'h01);
		pulse(1, 1);
		host.wr(PORT_CTRL, 8'h40);
		pulse(1, 2);
		host.wr(PORT_CTRL, 8'h40);
		rdchk(2'h1, 8'h02);
		rdchk(2'h1, 8'h01);
		rdchk(2'h1, 8'h00);
		rdchk(2'h1, 8'h01);
		host.wr(PORT_CTRL, 8'hf4);
		pulse(1, 1);
		rdchk(2'h1, 8'h30);
		rdchk(2'h1, 8'h00);
		rdchk(2'h1, 8'h01);
		rdchk(2'h1, 8'hff);
		rdchk(2'h1, 8'h00);
		$display("t_latch done");
	endtask
	task automatic t_mode1();
		host.wr(PORT_CTRL, 8'h92);
		chkpin(2, 1'b1);
		host.wr(2'h2, 8'h02);
		pulse(2, 2);
		chkpin(2, 1'b1);
		trig(2);
		pulse(2, 2);
		chkpin(2, 1'b0);
		pulse(2, 1);
		chkpin(2, 1'b1);
		trig(2);
		pulse(2, 1);
		chkpin(2, 1'b0);
		host.wr(2'h2, 8'h05);
		pulse(2, 2);
		chkpin(2, 1'b1);
		trig(2);
		pulse(2, 5);
		chkpin(2, 1'b0);
		pulse(2, 1);
		chkpin(2, 1'b1);
		$display("t_mode1 done");
	endtask
	// Decimal counting, high-byte format and a mode 2 start level
	task automatic t_bcd();
		host.wr(PORT_CTRL, 8'h31);
		host.wr(2'h0, 8'h00);
		host.wr(2'h0, 8'h01);
		pulse(0, 2);
		rdchk(2'h0, 8'h99);
		rdchk(2'h0, 8'h00);
		host.wr(PORT_CTRL, 8'h21);
		host.wr(2'h0, 8'h02);
		pulse(0, 2);
		rdchk(2'h0, 8'h01);
		host.wr(PORT_CTRL, 8'h14);
		chkpin(0, 1'b1);
		gate[0] = 1'b0;
		cyc(4);
		chkpin(0, 1'b1);
		$display("t_bcd done");
	endtask
	// Free-running system clock
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	initial begin
		sys_rst_in = 1'b1;
		tclk = 3'h0;
		gate = 3'h0;
		cyc(5);
		sys_rst_in = 1'b0;
		cyc(4);
		t_port();
		t_mode0();
		t_latch();
		t_mode1();
		t_bcd();
		end_of_test();
	end
	// Hang guard
	initial begin
		repeat (30000) @(posedge clk_in);
		$display("MISMATCH run exp done got hang");
		mismatches++;
		end_of_test();
	end
endmodule
